// ### bwlm_pkg.sv
/*
  Shared constants and carrier types for the burst write lane mask block.
  Assumes the controller presents pins synchronous to clk, with edge pulses
  marking the positive and complementary input clock rises.
*/
package bwlm_pkg;

  localparam int DATA_W    = 36;
  localparam int LANE_W    = 9;
  localparam int LANES     = 4;
  localparam int ADDR_W    = 6;
  localparam int DEPTH     = 64;
  localparam int FIFO_DEPTH = 32;

  // Lane enables usable in each width configuration, and the active-low select value that enables no lane
  localparam logic [3:0] LANES_18 = 4'h3;
  localparam logic [3:0] LANES_36 = 4'hf;
  localparam logic [3:0] LANES_NONE_N = 4'hf;

  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 6'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 6'h1;

  typedef enum logic [2:0] {
    BWLM_IDLE,
    BWLM_W_BEAT0,
    BWLM_W_BEAT1,
    BWLM_R_FETCH0,
    BWLM_R_FETCH1,
    BWLM_R_OUT0,
    BWLM_R_OUT1,
    BWLM_R_END
  } bwlm_state_e;

  // One burst beat on its way to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  lane_en;
  } bwlm_beat_s;

  localparam int BEAT_W = $bits(bwlm_beat_s);

endpackage

// ### bwlm_fifo.sv
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module bwlm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W-1:0] rd_ptr_nxt;
  logic [PTR_W:0]   count_r;
  logic [PTR_W:0]   count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Storage has no reset: contents are only read once counted in
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule

// ### bwlm_core.sv
/*
  Device side of a two-word burst SRAM: command decode, per-beat lane
  masking on both input clock rises, a write FIFO and the array itself.
  Assumes k_rise and kb_rise are one-cycle pulses synchronous to clk,
  never together and at least four clk cycles apart.
*/
// Contract
// - In 18-bit mode, select 0 low and select 1 high writes bits 8..0 only.
// - In 18-bit mode, select 0 high and select 1 low writes bits 17..9 only.
// - In 18-bit mode, both selects low writes the whole 18-bit beat.
// - In 18-bit mode, both selects high stores nothing for that beat.
// - In 36-bit mode, all four selects low writes the whole 36-bit beat.
// - In 36-bit mode, each low select enables its own 9-bit lane and leaves the rest unaltered.
// - In 36-bit mode, all four selects high writes nothing for that beat.
// - Each beat uses the selects sampled at its own clock rise, which may differ between beats.
// - Write data is taken and read data launched on rises of both input clocks.
// - Beat 0 goes to the latched address and beat 1 to the next address.
// - After reset the device is deselected with its data outputs released.
`timescale 1ns/1ps
module bwlm_core (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          width_36,
  input  wire logic                          k_rise,
  input  wire logic                          kb_rise,
  input  wire logic                          load_select_n,
  input  wire logic                          rw_select_n,
  input  wire logic [bwlm_pkg::ADDR_W-1:0]   addr,
  input  wire logic [bwlm_pkg::DATA_W-1:0]   data_in,
  input  wire logic [bwlm_pkg::LANES-1:0]    lane_write_select_n,
  output logic      [bwlm_pkg::DATA_W-1:0]   data_out,
  output logic                               data_oe,
  output logic                               write_ready,
  output logic                               width_36_active
);

  bwlm_pkg::bwlm_state_e state_r;
  bwlm_pkg::bwlm_state_e state_nxt;

  logic [bwlm_pkg::ADDR_W-1:0] addr_r;
  logic [bwlm_pkg::ADDR_W-1:0] addr_nxt;
  logic [bwlm_pkg::DATA_W-1:0] word0_r;
  logic [bwlm_pkg::DATA_W-1:0] word0_nxt;
  logic [bwlm_pkg::DATA_W-1:0] dout_r;
  logic [bwlm_pkg::DATA_W-1:0] dout_nxt;
  logic                        oe_r;
  logic                        oe_nxt;
  logic                        cfg_done_r;
  logic                        cfg_done_nxt;
  logic                        cfg_wide_r;
  logic                        cfg_wide_nxt;

  logic [bwlm_pkg::LANES-1:0]  lane_avail;
  logic [bwlm_pkg::LANES-1:0]  lane_en;
  bwlm_pkg::bwlm_beat_s        beat_in;
  bwlm_pkg::bwlm_beat_s        beat_out;
  logic                        beat_push;
  logic                        fifo_ready;
  logic                        beat_valid;
  logic                        drain;
  logic                        rd_en;
  logic [bwlm_pkg::ADDR_W-1:0] rd_addr;

  logic [bwlm_pkg::DATA_W-1:0] array_r [bwlm_pkg::DEPTH];
  logic [bwlm_pkg::DATA_W-1:0] rd_q_r;

  // Width strap caught once, on the first edge after reset release
  always_comb
  begin
    cfg_done_nxt = 1'b1;
    cfg_wide_nxt = cfg_done_r ? cfg_wide_r : width_36;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_done_r <= 1'b0;
      cfg_wide_r <= 1'b0;
    end
    else
    begin
      cfg_done_r <= cfg_done_nxt;
      cfg_wide_r <= cfg_wide_nxt;
    end
  end

  assign width_36_active = cfg_wide_r;

  // Active-low selects to per-lane enables; upper lanes dead in 18-bit mode
  assign lane_avail = cfg_wide_r ? bwlm_pkg::LANES_36 : bwlm_pkg::LANES_18;
  assign lane_en    = ~lane_write_select_n & lane_avail;

  // A beat with no lane enabled never reaches the array
  assign beat_push = (lane_en != '0) &&
                     (((state_r == bwlm_pkg::BWLM_W_BEAT0) && k_rise) ||
                      ((state_r == bwlm_pkg::BWLM_W_BEAT1) && kb_rise));

  always_comb
  begin
    beat_in.addr    = addr_r;
    beat_in.data    = data_in;
    beat_in.lane_en = lane_en;
    if (state_r == bwlm_pkg::BWLM_W_BEAT1)
    begin
      beat_in.addr = addr_r + bwlm_pkg::ADDR_STEP;
    end
  end

  // Controller must see write_ready high before issuing a write
  assign write_ready = fifo_ready;

  bwlm_fifo #(
    .WIDTH (bwlm_pkg::BEAT_W),
    .DEPTH (bwlm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (beat_in),
    .in_valid  (beat_push),
    .in_ready  (fifo_ready),
    .out_data  (beat_out),
    .out_valid (beat_valid),
    .out_ready (drain)
  );

  // Array reads win the single port; writes wait in the FIFO meanwhile
  assign rd_en   = (state_r == bwlm_pkg::BWLM_R_FETCH0) ||
                   (state_r == bwlm_pkg::BWLM_R_FETCH1);
  assign rd_addr = (state_r == bwlm_pkg::BWLM_R_FETCH1) ?
                   addr_r + bwlm_pkg::ADDR_STEP : addr_r;
  assign drain   = !rd_en;

  always_ff @(posedge clk)
  begin
    if (beat_valid && drain)
    begin
      for (int i = 0; i < bwlm_pkg::LANES; i++)
      begin
        if (beat_out.lane_en[i])
        begin
          array_r[beat_out.addr][i*bwlm_pkg::LANE_W +: bwlm_pkg::LANE_W] <=
            beat_out.data[i*bwlm_pkg::LANE_W +: bwlm_pkg::LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q_r <= bwlm_pkg::DATA_RST;
    end
    else if (rd_en)
    begin
      rd_q_r <= array_r[rd_addr];
    end
  end

  // Command and burst sequencing
  always_comb
  begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    word0_nxt = word0_r;
    dout_nxt  = dout_r;
    oe_nxt    = oe_r;
    unique case (state_r)
      bwlm_pkg::BWLM_IDLE:
      begin
        if (k_rise && !load_select_n)
        begin
          addr_nxt  = addr;
          state_nxt = rw_select_n ? bwlm_pkg::BWLM_R_FETCH0
                                  : bwlm_pkg::BWLM_W_BEAT0;
        end
      end
      bwlm_pkg::BWLM_W_BEAT0:
      begin
        if (k_rise)
        begin
          state_nxt = bwlm_pkg::BWLM_W_BEAT1;
        end
      end
      bwlm_pkg::BWLM_W_BEAT1:
      begin
        if (kb_rise)
        begin
          state_nxt = bwlm_pkg::BWLM_IDLE;
        end
      end
      bwlm_pkg::BWLM_R_FETCH0:
      begin
        state_nxt = bwlm_pkg::BWLM_R_FETCH1;
      end
      bwlm_pkg::BWLM_R_FETCH1:
      begin
        word0_nxt = rd_q_r;
        state_nxt = bwlm_pkg::BWLM_R_OUT0;
      end
      bwlm_pkg::BWLM_R_OUT0:
      begin
        if (kb_rise)
        begin
          dout_nxt  = word0_r;
          oe_nxt    = 1'b1;
          state_nxt = bwlm_pkg::BWLM_R_OUT1;
        end
      end
      bwlm_pkg::BWLM_R_OUT1:
      begin
        if (k_rise)
        begin
          dout_nxt  = rd_q_r;
          state_nxt = bwlm_pkg::BWLM_R_END;
        end
      end
      bwlm_pkg::BWLM_R_END:
      begin
        if (kb_rise)
        begin
          oe_nxt    = 1'b0;
          state_nxt = bwlm_pkg::BWLM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= bwlm_pkg::BWLM_IDLE;
      addr_r  <= bwlm_pkg::ADDR_RST;
      word0_r <= bwlm_pkg::DATA_RST;
      dout_r  <= bwlm_pkg::DATA_RST;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      word0_r <= word0_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe  = oe_r;

endmodule

// ### bwlm_core_properties.sv
/*
  Port-level timing checks for bwlm_core, bound onto every instance.
  Assumes one clk domain and the asynchronous active-low rst_n.
*/
`timescale 1ns/1ps
module bwlm_core_properties (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        k_rise,
  input wire logic                        kb_rise,
  input wire logic                        load_select_n,
  input wire logic                        rw_select_n,
  input wire logic [bwlm_pkg::LANES-1:0]  lane_write_select_n,
  input wire logic [bwlm_pkg::DATA_W-1:0] data_out,
  input wire logic                        data_oe,
  input wire logic                        width_36_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Read seen but not yet answered; a loose flag, it only widens the checks
  logic rd_pend_r;
  logic rd_pend_nxt;

  always_comb
  begin
    rd_pend_nxt = rd_pend_r;
    if (data_oe)
      rd_pend_nxt = 1'b0;
    if (k_rise && !load_select_n && rw_select_n)
      rd_pend_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rd_pend_r <= 1'b0;
    else
      rd_pend_r <= rd_pend_nxt;

  reset_quiet_a: assert property ($rose(rst_n) |-> !data_oe)
    else $error("data_oe high at reset release");
  oe_cause_a: assert property ($rose(data_oe) |-> $past(kb_rise))
    else $error("data_oe rose without a kb rise");
  oe_drop_a: assert property ($fell(data_oe) |-> $past(kb_rise))
    else $error("data_oe fell without a kb rise");
  oe_span_a: assert property ($rose(data_oe) |-> data_oe [*4])
    else $error("read burst cut short");
  out_hold_a: assert property (data_oe && $past(data_oe) && !$past(k_rise) && !$past(kb_rise)
    |-> $stable(data_out)) else $error("data_out moved between rises");
  read_first_a: assert property ($rose(data_oe) |-> rd_pend_r)
    else $error("data driven without a read");
  nop_quiet_a: assert property (k_rise && load_select_n && !data_oe && !rd_pend_r
    |=> !data_oe [*3]) else $error("data driven after a nop");
  width_hold_a: assert property (rst_n && $past(rst_n, 2) |-> $stable(width_36_active))
    else $error("width changed in mid-run");

  rd_burst_c: cover property ($rose(data_oe));
  wr_beat_c: cover property (kb_rise && lane_write_select_n != 4'hf && !data_oe);
  narrow_rd_c: cover property (!width_36_active && $rose(data_oe));
endmodule

bind bwlm_core bwlm_core_properties i_bwlm_core_properties (.clk, .rst_n, .k_rise, .kb_rise,
  .load_select_n, .rw_select_n, .lane_write_select_n, .data_out, .data_oe, .width_36_active);

// ### bwlm_ctrl_model.sv
/*
  Memory controller model: commands, burst beats and clock-rise pulses.
  Assumes the device samples everything on clk rises carrying a pulse.
*/
`timescale 1ns/1ps
module bwlm_ctrl_model (
  input  wire logic                   clk,
  output logic                        k_rise,
  output logic                        kb_rise,
  output logic                        load_select_n,
  output logic                        rw_select_n,
  output logic [bwlm_pkg::ADDR_W-1:0] addr,
  output logic [bwlm_pkg::DATA_W-1:0] data_in,
  output logic [bwlm_pkg::LANES-1:0]  lane_write_select_n
);
  initial
  begin
    {k_rise, kb_rise, load_select_n, rw_select_n} = 4'h3;
    {addr, data_in} = 42'h0;
    lane_write_select_n = 4'hf;
  end

  // One input clock rise, then junk on the lines so a late sample shows
  task automatic beat(input logic k, ld, rw, input logic [5:0] a, input logic [35:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    k_rise <= k;
    kb_rise <= !k;
    load_select_n <= ld;
    rw_select_n <= rw;
    addr <= a;
    data_in <= d;
    lane_write_select_n <= s;
    @(posedge clk);
    {k_rise, kb_rise} <= 2'h0;
    load_select_n <= 1'b1;
    rw_select_n <= ~rw;
    addr <= ~a;
    data_in <= ~d;
    lane_write_select_n <= ~s;
    repeat (2) @(posedge clk);
  endtask

  task automatic write(input logic [5:0] a, input logic [35:0] d0, input logic [3:0] l0,
                       input logic [35:0] d1, input logic [3:0] l1);
    beat(1'b1, 1'b0, 1'b0, a, ~d0, 4'hf);
    beat(1'b0, 1'b1, 1'b0, ~a, ~d1, 4'hf);
    beat(1'b1, 1'b1, 1'b0, ~a, d0, l0);
    beat(1'b0, 1'b1, 1'b0, ~a, d1, l1);
  endtask

  task automatic read(input logic [5:0] a);
    beat(1'b1, 1'b0, 1'b1, a, 36'h0, 4'hf);
    beat(1'b0, 1'b1, 1'b1, ~a, 36'h0, 4'hf);
    beat(1'b1, 1'b1, 1'b1, ~a, 36'h0, 4'hf);
    beat(1'b0, 1'b1, 1'b1, ~a, 36'h0, 4'hf);
  endtask
endmodule

// ### tb_top.sv
/*
  Top bench: bwlm_core behind the controller model; write FIFO seen only through the top.
  Assumes the package, design and model files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, width_36, k_rise, kb_rise, load_select_n, rw_select_n;
  logic        data_oe, write_ready, width_36_active, was_edge;
  logic [5:0]  addr, a;
  logic [35:0] data_in, data_out, msk, e;
  logic [3:0]  lane_write_select_n;
  logic [35:0] shadow [64];
  logic [35:0] exp_q [$];
  logic [31:0] seed = 32'h4c5e;
  int          errors, total_checks;

  bwlm_core i_bwlm_core (.clk, .rst_n, .width_36, .k_rise, .kb_rise, .load_select_n,
    .rw_select_n, .addr, .data_in, .lane_write_select_n, .data_out, .data_oe, .write_ready,
    .width_36_active);
  bwlm_ctrl_model i_bwlm_ctrl_model (.clk, .k_rise, .kb_rise, .load_select_n, .rw_select_n,
    .addr, .data_in, .lane_write_select_n);

  assign msk = width_36 ? 36'hf_ffff_ffff : 36'h0_0003_ffff;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [35:0] r36();
    return 36'({rnd(), rnd()});
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] old, d, input logic [3:0] s);
    merge = old;
    for (int i = 0; i < (width_36 ? 4 : 2); i++)
      if (!s[i])
        merge[9*i+:9] = d[9*i+:9];
  endfunction

  task automatic check(input string what, input logic [35:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [35:0] d0, d1, input logic [3:0] l0, l1);
    shadow[a] = merge(shadow[a], d0, l0);
    shadow[a+6'h1] = merge(shadow[a+6'h1], d1, l1);
    i_bwlm_ctrl_model.write(a, d0, l0, d1, l1);
  endtask

  task automatic rd(input logic [5:0] a);
    exp_q.push_back(shadow[a]);
    exp_q.push_back(shadow[a+6'h1]);
    i_bwlm_ctrl_model.read(a);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Read words appear one cycle after the rise that launched them
  always @(posedge clk)
  begin
    if (data_oe === 1'b1 && was_edge === 1'b1)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 36'hx;
      check("data_out", data_out & msk, e & msk);
    end
    was_edge <= k_rise | kb_rise;
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    width_36 = 1'b1;
    was_edge = 1'b0;
    for (int m = 1; m >= 0; m--)
    begin
      rst_n <= 1'b0;
      width_36 <= m[0];
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("data_oe", {35'h0, data_oe}, 36'h0);
      check("data_out", data_out, 36'h0);
      check("write_ready", {35'h0, write_ready}, 36'h1);
      check("width", {35'h0, width_36_active}, {35'h0, width_36});
      for (int p = 0; p < 16; p++)
      begin
        a = (p == 0) ? 6'h3f : 6'(rnd());
        wr(a, r36(), r36(), 4'h0, 4'h0);
        wr(a, r36(), r36(), p[3:0], ~p[3:0]);
        check("write_ready", {35'h0, write_ready}, 36'h1);
        rd(a);
      end
    end
    // FIFO drains a beat per idle cycle, so write_ready must be high; every queued read word must also be checked and gone
    repeat (8) @(posedge clk);
    check("write_ready", {35'h0, write_ready}, 36'h1);
    check("reads left", 36'(exp_q.size()), 36'h0);
    final_report();
  end
endmodule
